// ### logic/mem_cfg_regs.vh
// register offsets, field positions and reset values of the memory config bank
`ifndef MEM_CFG_REGS_VH
`define MEM_CFG_REGS_VH

// offsets
`define OFS_CFG_TWO      32'h8000_0004
`define OFS_CFG_THREE    32'h0800_0008
`define OFS_MASK_ONE     32'h8000_001c
`define OFS_MASK_TWO     32'h8000_0020
`define OFS_SEG_STA_ONE  32'h8000_0000
`define OFS_SEG_END_ONE  32'h8000_00d4
`define OFS_SEG_STA_TWO  32'h8000_00d8
`define OFS_SEG_END_TWO  32'h8000_00dc

// memory_config_two fields
`define C2_REF_EN        31
`define C2_SDBS          25:23
`define C2_SDBS_TOP      3'h7
`define C2_COLS          22:21
`define C2_CMD           20:19
`define C2_SDRAM_ON      14
`define C2_SRAM_OFF      13
`define C2_RAMBS         12:9
`define C2_BUS_READY_N_EN       7
`define C2_RMW           6
`define C2_WIDTH_HI      5
`define C2_WWS           3:2
`define C2_RWS           1:0
`define C2_WMASK         32'hfff8_7eff
`define C2_RESET         32'h7c00_0000

// sdram commands
`define CMD_NONE         2'h0
`define CMD_PRECHARGE    2'h1
`define CMD_REFRESH      2'h2
`define CMD_LOAD_MODE    2'h3

// memory_config_three fields
`define C3_RFC_VAL       2'h3
`define C3_RFC           31:30
`define C3_ME            27
`define C3_RELOAD        26:12
`define C3_WB            11
`define C3_RB            10
`define C3_RE            9
`define C3_PE            8
`define C3_TCB           7:0
`define C3_WMASK         32'h07ff_feff
`define C3_RESET         32'h0000_0000

// protection fields
`define WP_EN            31
`define WP_BP            30
`define WP_TAG           29:15
`define WP_MASK          14:0
`define WP_ADDR_TAG      29:15
`define SEG_ADDR         29:2
`define SEG_BP           1
`define SEG_US           1
`define SEG_SU           0
`define WP_WMASK         32'hffff_ffff
`define SEG_STA_WMASK    32'h3fff_fffe
`define SEG_END_WMASK    32'h3fff_ffff
`define WP_RESET         32'h0000_0000

`endif

// ### logic/memory_config_and_write_protect.v
// memory controller configuration registers and write protection units
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`include "mem_cfg_regs.vh"

module memory_config_and_write_protect #(
    parameter MEM_EDAC_PRESENT = 1'b1
) (
    // clock and reset
    input  wire        ref_clk_in,
    input  wire        nrst_in,
    // register port
    input  wire [31:0] reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [31:0] reg_rdata_out,
    // pins
    input  wire        bus_ready_n_in,
    input  wire        gpio2_in,
    // memory controller side
    input  wire        sdram_cmd_done_in,
    input  wire        bank4_access_in,
    input  wire        sub_word_write_in,
    input  wire        sdram_area_in,
    input  wire        shared_strobe_in,
    input  wire [7:0]  edac_cb_in,
    input  wire [7:0]  mem_cb_in,
    input  wire        load_done_in,
    // cpu write checking
    input  wire        cpu_wr_in,
    input  wire [31:0] cpu_wr_addr_in,
    input  wire        cpu_user_in,
    // decoded configuration
    output reg  [9:0]  sdram_bank_mb_out,
    output reg  [12:0] sdram_cols_out,
    output reg  [18:0] sram_bank_kb_out,
    output reg         sdram_on_out,
    output reg         sram_off_out,
    output reg         sram_bus32_out,
    output reg  [1:0]  sram_wr_waits_out,
    output reg  [1:0]  sram_rd_waits_out,
    output reg         ram_edac_on_out,
    output reg         prom_edac_on_out,
    // memory actions
    output reg  [1:0]  sdram_cmd_out,
    output reg         sdram_cmd_valid_out,
    output reg         bank4_stall_out,
    output reg         sram_rmw_out,
    output reg         sdram_rmw_out,
    output reg  [7:0]  store_cb_out,
    output reg         wp_error_out
);

// ****************************************************************
// helpers
// ****************************************************************
function mask_hit;
    input [31:0] unit;
    input [31:0] addr;
    begin
        mask_hit = (((unit[`WP_TAG] ^ addr[`WP_ADDR_TAG])
                    & unit[`WP_MASK]) == 15'h0000);
    end
endfunction

function seg_hit;
    input [31:0] sta;
    input [31:0] stp;
    input [31:0] addr;
    begin
        seg_hit = (addr[`SEG_ADDR] >= sta[`SEG_ADDR]) &&
                  (addr[`SEG_ADDR] <= stp[`SEG_ADDR]);
    end
endfunction

function seg_active;
    input [31:0] stp;
    input        user;
    begin
        seg_active = user ? stp[`SEG_US] : stp[`SEG_SU];
    end
endfunction

function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] wm;
    begin
        merge = (old & ~wm) | (wd & wm);
    end
endfunction

// ****************************************************************
// storage
// ****************************************************************
reg  [31:0] cfg_two_q;
reg  [31:0] cfg_three_q;
reg  [31:0] mask_one_q;
reg  [31:0] mask_two_q;
reg  [31:0] seg_sta_one_q;
reg  [31:0] seg_end_one_q;
reg  [31:0] seg_sta_two_q;
reg  [31:0] seg_end_two_q;
reg  [1:0]  bus_ready_n_sync_q;
reg  [1:0]  gpio_sync_q;
reg  [14:0] refresh_cnt_q;
reg         cmd_busy_q;
reg         refresh_pend_q;

wire wr_two   = reg_wr_in && (reg_addr_in == `OFS_CFG_TWO);
wire wr_three = reg_wr_in && (reg_addr_in == `OFS_CFG_THREE);
wire refresh_on = cfg_two_q[`C2_REF_EN] && cfg_two_q[`C2_SDRAM_ON];
wire edac_on    = cfg_three_q[`C3_RE];

// ****************************************************************
// pin synchronisers
// ****************************************************************
// left without reset so the gpio strap is already valid while reset
// is held and can be caught into the prom edac bit
always @(posedge ref_clk_in) begin
    bus_ready_n_sync_q <= {bus_ready_n_sync_q[0], bus_ready_n_in};
    gpio_sync_q <= {gpio_sync_q[0], gpio2_in};
end

// ****************************************************************
// register writes
// ****************************************************************
always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
        cfg_two_q     <= `C2_RESET;
        cfg_three_q   <= `C3_RESET;
        mask_one_q    <= `WP_RESET;
        mask_two_q    <= `WP_RESET;
        seg_sta_one_q <= `WP_RESET;
        seg_end_one_q <= `WP_RESET;
        seg_sta_two_q <= `WP_RESET;
        seg_end_two_q <= `WP_RESET;
        cfg_three_q[`C3_PE] <= gpio_sync_q[1];
    end else begin
        if (wr_two) begin
            cfg_two_q <= merge(cfg_two_q, reg_wdata_in, `C2_WMASK);
        end else if (sdram_cmd_done_in && cmd_busy_q) begin
            cfg_two_q[`C2_CMD] <= `CMD_NONE;
        end
        if (wr_three) begin
            cfg_three_q <= merge(cfg_three_q, reg_wdata_in, `C3_WMASK);
        end
        // hardware capture wins over a software write in the same cycle
        if (cfg_three_q[`C3_RB] && load_done_in) begin
            cfg_three_q[`C3_TCB] <= mem_cb_in;
        end
        if (reg_wr_in) begin
            case (reg_addr_in)
                `OFS_MASK_ONE: begin
                    mask_one_q <= reg_wdata_in & `WP_WMASK;
                end
                `OFS_MASK_TWO: begin
                    mask_two_q <= reg_wdata_in & `WP_WMASK;
                end
                `OFS_SEG_STA_ONE: begin
                    seg_sta_one_q <= reg_wdata_in & `SEG_STA_WMASK;
                end
                `OFS_SEG_END_ONE: begin
                    seg_end_one_q <= reg_wdata_in & `SEG_END_WMASK;
                end
                `OFS_SEG_STA_TWO: begin
                    seg_sta_two_q <= reg_wdata_in & `SEG_STA_WMASK;
                end
                `OFS_SEG_END_TWO: begin
                    seg_end_two_q <= reg_wdata_in & `SEG_END_WMASK;
                end
                default: begin
                end
            endcase
        end
    end
end

// ****************************************************************
// register reads
// ****************************************************************
reg [31:0] rd_d;
always @* begin
    rd_d = 32'h0000_0000;
    case (reg_addr_in)
        `OFS_CFG_TWO: begin
            rd_d = cfg_two_q;
        end
        `OFS_CFG_THREE: begin
            rd_d = cfg_three_q;
            rd_d[`C3_RFC] = `C3_RFC_VAL;
            rd_d[`C3_ME]  = MEM_EDAC_PRESENT;
        end
        `OFS_MASK_ONE: begin
            rd_d = mask_one_q;
        end
        `OFS_MASK_TWO: begin
            rd_d = mask_two_q;
        end
        `OFS_SEG_STA_ONE: begin
            rd_d = seg_sta_one_q;
        end
        `OFS_SEG_END_ONE: begin
            rd_d = seg_end_one_q;
        end
        `OFS_SEG_STA_TWO: begin
            rd_d = seg_sta_two_q;
        end
        `OFS_SEG_END_TWO: begin
            rd_d = seg_end_two_q;
        end
        default: begin
            rd_d = 32'h0000_0000;
        end
    endcase
end

always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
        reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
        reg_rdata_out <= rd_d;
    end else begin
        reg_rdata_out <= 32'h0000_0000;
    end
end

// ****************************************************************
// sdram commands and refresh
// ****************************************************************
// a software command has priority; a due refresh waits until free
always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
        sdram_cmd_out       <= `CMD_NONE;
        sdram_cmd_valid_out <= 1'b0;
        cmd_busy_q          <= 1'b0;
        refresh_cnt_q       <= 15'h0000;
        refresh_pend_q      <= 1'b0;
    end else begin
        sdram_cmd_valid_out <= 1'b0;
        if (cmd_busy_q) begin
            if (sdram_cmd_done_in) begin
                cmd_busy_q <= 1'b0;
            end
        end else if (cfg_two_q[`C2_SDRAM_ON]) begin
            if (cfg_two_q[`C2_CMD] != `CMD_NONE) begin
                sdram_cmd_out       <= cfg_two_q[`C2_CMD];
                sdram_cmd_valid_out <= 1'b1;
                cmd_busy_q          <= 1'b1;
            end else if (refresh_pend_q) begin
                sdram_cmd_out       <= `CMD_REFRESH;
                sdram_cmd_valid_out <= 1'b1;
                refresh_pend_q      <= 1'b0;
            end
        end
        if (!refresh_on) begin
            refresh_cnt_q  <= cfg_three_q[`C3_RELOAD];
            refresh_pend_q <= 1'b0;
        end else if (refresh_cnt_q == 15'h0000) begin
            refresh_cnt_q  <= cfg_three_q[`C3_RELOAD];
            refresh_pend_q <= 1'b1;
        end else begin
            refresh_cnt_q <= refresh_cnt_q - 15'h0001;
        end
    end
end

// ****************************************************************
// decoded configuration and memory actions
// ****************************************************************
reg [12:0] cols_d;
always @* begin
    case (cfg_two_q[`C2_COLS])
        2'h0: cols_d = 13'h0100;
        2'h1: cols_d = 13'h0200;
        2'h2: cols_d = 13'h0400;
        default: begin
            if (cfg_two_q[`C2_SDBS] == `C2_SDBS_TOP) begin
                cols_d = 13'h1000;
            end else begin
                cols_d = 13'h0800;
            end
        end
    endcase
end

always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
        sdram_bank_mb_out <= 10'h000;
        sdram_cols_out    <= 13'h0000;
        sram_bank_kb_out  <= 19'h00000;
        sdram_on_out      <= 1'b0;
        sram_off_out      <= 1'b0;
        sram_bus32_out    <= 1'b0;
        sram_wr_waits_out <= 2'h0;
        sram_rd_waits_out <= 2'h0;
        ram_edac_on_out   <= 1'b0;
        prom_edac_on_out  <= 1'b0;
        bank4_stall_out   <= 1'b0;
        sram_rmw_out      <= 1'b0;
        sdram_rmw_out     <= 1'b0;
        store_cb_out      <= 8'h00;
    end else begin
        sdram_bank_mb_out <= 10'h004 << cfg_two_q[`C2_SDBS];
        sdram_cols_out    <= cols_d;
        sram_bank_kb_out  <= 19'h00008 << cfg_two_q[`C2_RAMBS];
        sdram_on_out      <= cfg_two_q[`C2_SDRAM_ON];
        sram_off_out      <= cfg_two_q[`C2_SRAM_OFF] &
                             cfg_two_q[`C2_SDRAM_ON];
        // code 01 is undefined and falls back to the 8-bit bus
        sram_bus32_out    <= cfg_two_q[`C2_WIDTH_HI];
        sram_wr_waits_out <= cfg_two_q[`C2_WWS];
        sram_rd_waits_out <= cfg_two_q[`C2_RWS];
        ram_edac_on_out   <= edac_on;
        prom_edac_on_out  <= cfg_three_q[`C3_PE];
        bank4_stall_out   <= cfg_two_q[`C2_BUS_READY_N_EN] & bank4_access_in &
                             bus_ready_n_sync_q[1];
        // edac integrity also needs sram rmw set by software first
        sram_rmw_out      <= cfg_two_q[`C2_RMW] & sub_word_write_in &
                             !sdram_area_in &
                             (shared_strobe_in | edac_on);
        sdram_rmw_out     <= edac_on & sub_word_write_in &
                             sdram_area_in;
        store_cb_out      <= cfg_three_q[`C3_WB] ? cfg_three_q[`C3_TCB]
                             : edac_cb_in;
    end
end

// ****************************************************************
// write protection
// ****************************************************************
reg blocked_d;
reg allow_any_d;
reg allowed_d;
always @* begin
    blocked_d   = 1'b0;
    allow_any_d = 1'b0;
    allowed_d   = 1'b0;
    if (mask_one_q[`WP_EN]) begin
        if (mask_one_q[`WP_BP]) begin
            blocked_d = blocked_d | mask_hit(mask_one_q, cpu_wr_addr_in);
        end else begin
            allow_any_d = 1'b1;
            allowed_d = allowed_d | mask_hit(mask_one_q, cpu_wr_addr_in);
        end
    end
    if (mask_two_q[`WP_EN]) begin
        if (mask_two_q[`WP_BP]) begin
            blocked_d = blocked_d | mask_hit(mask_two_q, cpu_wr_addr_in);
        end else begin
            allow_any_d = 1'b1;
            allowed_d = allowed_d | mask_hit(mask_two_q, cpu_wr_addr_in);
        end
    end
    if (seg_active(seg_end_one_q, cpu_user_in)) begin
        if (seg_sta_one_q[`SEG_BP]) begin
            blocked_d = blocked_d |
                seg_hit(seg_sta_one_q, seg_end_one_q, cpu_wr_addr_in);
        end else begin
            allow_any_d = 1'b1;
            allowed_d = allowed_d |
                seg_hit(seg_sta_one_q, seg_end_one_q, cpu_wr_addr_in);
        end
    end
    if (seg_active(seg_end_two_q, cpu_user_in)) begin
        if (seg_sta_two_q[`SEG_BP]) begin
            blocked_d = blocked_d |
                seg_hit(seg_sta_two_q, seg_end_two_q, cpu_wr_addr_in);
        end else begin
            allow_any_d = 1'b1;
            allowed_d = allowed_d |
                seg_hit(seg_sta_two_q, seg_end_two_q, cpu_wr_addr_in);
        end
    end
end

always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
        wp_error_out <= 1'b0;
    end else begin
        wp_error_out <= cpu_wr_in &
                        (blocked_d | (allow_any_d & !allowed_d));
    end
end

endmodule // memory_config_and_write_protect

// ### tb/mem_cfg_checker_assertions.sv
// concurrent port checks of the memory config block
`timescale 1ns/10ps
module mem_cfg_checker (
    // clock and reset
    input wire        ref_clk_in,
    input wire        nrst_in,
    // watched inputs
    input wire        bank4_access_in,
    input wire        sub_word_write_in,
    input wire        sdram_area_in,
    input wire        cpu_wr_in,
    // watched outputs
    input wire [9:0]  sdram_bank_mb_out,
    input wire [12:0] sdram_cols_out,
    input wire [18:0] sram_bank_kb_out,
    input wire        sdram_on_out,
    input wire        sram_off_out,
    input wire [1:0]  sdram_cmd_out,
    input wire        sdram_cmd_valid_out,
    input wire        bank4_stall_out,
    input wire        sram_rmw_out,
    input wire        sdram_rmw_out,
    input wire        wp_error_out
);
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    bank_size_a: assert property (
        $onehot0(sdram_bank_mb_out) && sdram_bank_mb_out[1:0] == 2'h0)
        else $error("sdram size off scale");
    cols_top_a: assert property (sdram_cols_out == 13'h1000 |->
        sdram_bank_mb_out == 10'h200) else $error("4096 columns wrongly");
    sram_size_a: assert property (
        $onehot0(sram_bank_kb_out) && sram_bank_kb_out[2:0] == 3'h0)
        else $error("sram size off scale");
    cmd_gate_a: assert property (sdram_cmd_valid_out |->
        sdram_on_out && sdram_cmd_out != 2'h0) else $error("bad command");
    sram_off_a: assert property (sram_off_out |-> sdram_on_out)
        else $error("sram off without sdram on");
    stall_cause_a: assert property (bank4_stall_out |->
        $past(bank4_access_in)) else $error("stall without bank four");
    sram_rmw_a: assert property (sram_rmw_out |->
        $past(sub_word_write_in && !sdram_area_in)) else $error("sram rmw");
    sdram_rmw_a: assert property (sdram_rmw_out |->
        $past(sub_word_write_in && sdram_area_in)) else $error("sdram rmw");
    wp_err_a: assert property (wp_error_out |-> $past(cpu_wr_in))
        else $error("error without a write");

    cmd_c: cover property (sdram_cmd_valid_out);
    wp_c: cover property (wp_error_out);
    stall_c: cover property (bank4_stall_out);
    rmw_c: cover property (sram_rmw_out);
endmodule // mem_cfg_checker

bind memory_config_and_write_protect mem_cfg_checker u_chk (
    .ref_clk_in, .nrst_in, .bank4_access_in, .sub_word_write_in,
    .sdram_area_in, .cpu_wr_in, .sdram_bank_mb_out, .sdram_cols_out,
    .sram_bank_kb_out, .sdram_on_out, .sram_off_out, .sdram_cmd_out,
    .sdram_cmd_valid_out, .bank4_stall_out, .sram_rmw_out,
    .sdram_rmw_out, .wp_error_out
);

// ### tb/mem_side_model.sv
// far-side model: sdram command sequencer and bank four ready source
`timescale 1ns/10ps
module mem_side_model (
    // clock and reset
    input  wire       ref_clk_in,
    input  wire       nrst_in,
    // from the controller
    input  wire       cmd_valid_in,
    input  wire       bank4_sel_in,
    input  wire [3:0] delay_in,
    // to the controller
    output reg        cmd_done_out,
    output reg        ready_n_out
);
    reg [3:0] cnt_q;
    reg       busy_q;
    reg [3:0] wait_q;

    always @(posedge ref_clk_in) begin
        cmd_done_out <= 1'b0;
        if (!nrst_in) begin
            busy_q <= 1'b0;
            cnt_q  <= 4'h0;
        end else if (cmd_valid_in) begin
            busy_q <= 1'b1;
            cnt_q  <= delay_in;
        end else if (busy_q && cnt_q == 4'h0) begin
            busy_q       <= 1'b0;
            cmd_done_out <= 1'b1;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    // pulled up: high while bank four is unselected
    always @(posedge ref_clk_in) begin
        if (!nrst_in || !bank4_sel_in) begin
            wait_q      <= 4'h0;
            ready_n_out <= 1'b1;
        end else if (wait_q == delay_in) begin
            ready_n_out <= 1'b0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule // mem_side_model

// ### tb/memory_config_and_write_protect_tb.sv
// self-checking bench for the memory config and protect block
`timescale 1ns/10ps
`include "mem_cfg_regs.vh"
module memory_config_and_write_protect_tb;
    reg         ref_clk_in = 1'b0;
    reg         nrst_in = 1'b0;
    reg  [31:0] reg_addr_in = 32'h0;
    reg  [31:0] reg_wdata_in = 32'h0;
    reg         reg_wr_in = 1'b0;
    reg         reg_rd_in = 1'b0;
    reg         gpio2_in = 1'b1;
    reg         bank4_access_in = 1'b0;
    reg         sub_word_write_in = 1'b0;
    reg         sdram_area_in = 1'b0;
    reg         shared_strobe_in = 1'b0;
    reg  [7:0]  edac_cb_in = 8'h3c;
    reg  [7:0]  mem_cb_in = 8'h00;
    reg         load_done_in = 1'b0;
    reg         cpu_wr_in = 1'b0;
    reg  [31:0] cpu_wr_addr_in = 32'h0;
    reg         cpu_user_in = 1'b0;
    reg  [3:0]  delay_q = 4'h9;
    wire        bus_ready_n_in;
    wire        sdram_cmd_done_in;
    wire [31:0] reg_rdata_out;
    wire [9:0]  sdram_bank_mb_out;
    wire [12:0] sdram_cols_out;
    wire [18:0] sram_bank_kb_out;
    wire [1:0]  sram_wr_waits_out, sram_rd_waits_out, sdram_cmd_out;
    wire [7:0]  store_cb_out;
    wire        sdram_on_out, sram_off_out, sram_bus32_out, ram_edac_on_out;
    wire        prom_edac_on_out, sdram_cmd_valid_out, bank4_stall_out;
    wire        sram_rmw_out, sdram_rmw_out, wp_error_out;
    integer     n_errors = 0;
    integer     compares = 0;
    integer     i;
    reg  [4:0]  k;
    reg  [1:0]  code;
    reg  [31:0] d;
    reg  [95:0] rows [0:8];

    always #5 ref_clk_in = ~ref_clk_in;

    memory_config_and_write_protect dut (.*);
    mem_side_model far (.ref_clk_in, .nrst_in,
        .cmd_valid_in(sdram_cmd_valid_out), .bank4_sel_in(bank4_access_in),
        .delay_in(delay_q), .cmd_done_out(sdram_cmd_done_in),
        .ready_n_out(bus_ready_n_in));

    // ****************
    // tasks
    // ****************
    task chk(input [31:0] got, input [31:0] exp, input string what);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: %s %h not %h", $time, what,
                         got, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("compares %0d n_errors %0d", compares, n_errors);
            if (n_errors == 0 && compares > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task wr(input [31:0] a, input [31:0] v);
        begin
            @(posedge ref_clk_in);
            reg_addr_in  <= a;
            reg_wdata_in <= v;
            reg_wr_in    <= 1'b1;
            @(posedge ref_clk_in);
            reg_wr_in <= 1'b0;
        end
    endtask
    task rd(input [31:0] a);
        begin
            @(posedge ref_clk_in);
            reg_addr_in <= a;
            reg_rd_in   <= 1'b1;
            @(posedge ref_clk_in);
            reg_rd_in <= 1'b0;
            @(negedge ref_clk_in);
            d = reg_rdata_out;
        end
    endtask
    task settle;
        repeat (2) @(negedge ref_clk_in);
    endtask
    // code stays 0 if no command in n cycles
    task wait_cmd(input integer n);
        begin
            code = 2'h0;
            for (i = 0; i < n && code == 2'h0; i = i + 1) begin
                @(negedge ref_clk_in);
                if (sdram_cmd_valid_out === 1'b1)
                    code = sdram_cmd_out;
            end
        end
    endtask
    task wp(input [31:0] a, input u, input e);
        begin
            @(posedge ref_clk_in);
            cpu_wr_in      <= 1'b1;
            cpu_wr_addr_in <= a;
            cpu_user_in    <= u;
            @(posedge ref_clk_in);
            cpu_wr_in <= 1'b0;
            @(negedge ref_clk_in);
            chk(wp_error_out, e, "protect");
        end
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        rows[0] = {`OFS_CFG_TWO, 32'h7fe7_ffff, 32'h7fe0_7eff};
        rows[1] = {`OFS_CFG_THREE, 32'hffff_ffff, 32'hcfff_ffff};
        rows[2] = {`OFS_MASK_ONE, 32'h1234_5678, 32'h1234_5678};
        rows[3] = {`OFS_MASK_TWO, 32'ha5a5_a5a5, 32'ha5a5_a5a5};
        rows[4] = {`OFS_SEG_STA_ONE, 32'hffff_ffff, 32'h3fff_fffe};
        rows[5] = {`OFS_SEG_END_ONE, 32'hffff_ffff, 32'h3fff_ffff};
        rows[6] = {`OFS_SEG_STA_TWO, 32'hffff_ffff, 32'h3fff_fffe};
        rows[7] = {`OFS_SEG_END_TWO, 32'hffff_ffff, 32'h3fff_ffff};
        rows[8] = {32'h8000_0008, 32'hffff_ffff, 32'h0};
        repeat (20) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        rd(`OFS_CFG_TWO);
        chk(d, `C2_RESET, "cfg two");
        rd(`OFS_CFG_THREE);
        chk(d, 32'hc800_0100, "cfg three");
        chk(prom_edac_on_out, 1'b1, "prom edac");
        $display("test reset done");
        for (k = 0; k < 9; k = k + 1) begin
            wr(rows[k][95:64], rows[k][63:32]);
            rd(rows[k][95:64]);
            chk(d, rows[k][31:0], "row");
        end
        $display("test rows done");
        for (k = 0; k < 8; k = k + 1) begin
            d = 32'h0000_2010 | {k[2:0], 23'h0} | {k[0], 14'h0};
            d = d | {k[2:0], 10'h200} | {k[0], 5'h0} | {~k[1:0], k[1:0]};
            d[`C2_COLS] = (k < 3) ? k[1:0] : 2'h3;
            wr(`OFS_CFG_TWO, d);
            settle;
            chk({sdram_bank_mb_out, sdram_cols_out}, {10'd4 << k[2:0],
                (k < 3) ? 13'd256 << k : (k == 7) ? 13'd4096 : 13'd2048},
                "sdram size");
            chk(sram_bank_kb_out, 19'd8 << {k[2:0], 1'b1}, "sram");
            chk({sdram_on_out, sram_off_out, sram_bus32_out,
                sram_wr_waits_out, sram_rd_waits_out}, {k[0], k[0], k[0],
                ~k[1:0], k[1:0]}, "sram cfg");
        end
        $display("test decode done");
        for (k = 1; k < 4; k = k + 1) begin
            wr(`OFS_CFG_TWO, 32'h0000_4000 | {k[1:0], 19'h0});
            wait_cmd(20);
            chk(code, k[1:0], "command");
            if (code === 2'h0)
                conclude;
            rd(`OFS_CFG_TWO);
            chk(d[20:19], k[1:0], "busy field");
            for (i = 0; i < 12 && d[20:19] !== 2'h0; i = i + 1)
                rd(`OFS_CFG_TWO);
            chk(d[20:19], 2'h0, "field clear");
        end
        wr(`OFS_CFG_TWO, 32'h0008_0000);
        wait_cmd(10);
        chk(code, 2'h0, "refused");
        rd(`OFS_CFG_TWO);
        chk(d[20:19], 2'h1, "held field");
        wr(`OFS_CFG_TWO, 32'h0);
        $display("test commands done");
        delay_q <= 4'h0;
        wr(`OFS_CFG_THREE, 32'h0000_5000);
        wr(`OFS_CFG_TWO, 32'h8000_4000);
        wait_cmd(40);
        chk(code, `CMD_REFRESH, "refresh");
        if (code === 2'h0)
            conclude;
        wait_cmd(40);
        chk(i, 6, "refresh interval");
        wr(`OFS_CFG_TWO, 32'h0);
        $display("test refresh done");
        wr(`OFS_CFG_TWO, 32'h40);
        for (k = 0; k < 16; k = k + 1) begin
            if (k[2:0] == 3'h0)
                wr(`OFS_CFG_THREE, {22'h0, k[3], 9'h0});
            @(posedge ref_clk_in);
            sub_word_write_in <= k[0];
            sdram_area_in     <= k[1];
            shared_strobe_in  <= k[2];
            settle;
            chk({sram_rmw_out, sdram_rmw_out, ram_edac_on_out},
                {k[0] & ~k[1] & (k[2] | k[3]), k[0] & k[1] & k[3], k[3]},
                "rmw");
        end
        $display("test rmw done");
        wr(`OFS_CFG_THREE, 32'h0000_085a);
        settle;
        chk(store_cb_out, 8'h5a, "bypass");
        wr(`OFS_CFG_THREE, 32'h0000_045a);
        settle;
        chk(store_cb_out, 8'h3c, "computed");
        @(posedge ref_clk_in);
        load_done_in <= 1'b1;
        mem_cb_in    <= 8'h81;
        @(posedge ref_clk_in);
        load_done_in <= 1'b0;
        rd(`OFS_CFG_THREE);
        chk(d[7:0], 8'h81, "capture");
        $display("test checkbits done");
        delay_q <= 4'h6;
        wr(`OFS_CFG_TWO, 32'h80);
        @(posedge ref_clk_in);
        bank4_access_in <= 1'b1;
        for (i = 0; i < 10 && bank4_stall_out !== 1'b1; i = i + 1)
            @(negedge ref_clk_in);
        chk(bank4_stall_out, 1'b1, "stalled");
        for (i = 0; i < 20 && bank4_stall_out !== 1'b0; i = i + 1)
            @(negedge ref_clk_in);
        chk(bank4_stall_out, 1'b0, "released");
        $display("test bus ready done");
        wr(`OFS_SEG_END_ONE, 32'h0);
        wr(`OFS_SEG_END_TWO, 32'h0);
        wr(`OFS_MASK_TWO, 32'h0);
        wr(`OFS_MASK_ONE, 32'hc091_fffe);
        wp(32'h0091_8000, 1'b0, 1'b1);
        wp(32'h0091_0000, 1'b0, 1'b1);
        wp(32'h0093_8000, 1'b0, 1'b0);
        wr(`OFS_MASK_ONE, 32'h8091_fffe);
        wp(32'h0091_8000, 1'b0, 1'b0);
        wp(32'h0093_8000, 1'b0, 1'b1);
        wr(`OFS_MASK_ONE, 32'h0091_fffe);
        wp(32'h0093_8000, 1'b0, 1'b0);
        wr(`OFS_SEG_STA_ONE, 32'h0000_1002);
        wr(`OFS_SEG_END_ONE, 32'h0000_1ffe);
        wp(32'h0000_1ffc, 1'b1, 1'b1);
        wp(32'h0000_1000, 1'b1, 1'b1);
        wp(32'h0000_2000, 1'b1, 1'b0);
        wp(32'h0000_1800, 1'b0, 1'b0);
        wr(`OFS_SEG_END_ONE, 32'h0000_1ffd);
        wp(32'h0000_1800, 1'b0, 1'b1);
        wp(32'h0000_1800, 1'b1, 1'b0);
        $display("test protect done");
        @(posedge ref_clk_in);
        gpio2_in <= 1'b0;
        nrst_in  <= 1'b0;
        repeat (5) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        rd(`OFS_CFG_THREE);
        chk(d, 32'hc800_0000, "strap low");
        chk(prom_edac_on_out, 1'b0, "prom edac");
        $display("test reset two done");
        conclude;
    end
endmodule // memory_config_and_write_protect_tb
